// File: inc/bcb_pkg.sv
`default_nettype none
package bcb_pkg;
  // clock and quarter phases
  localparam int CLK_PERIOD_NS = 4;
  localparam int Q_PER_CYCLE = 4;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  // widths
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int DATA_W = 8;
  localparam int OFS_W = 8;
  // instruction fields
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int SUB_MSB = 11;
  localparam int SUB_LSB = 8;
  localparam int BIT_MSB = 11;
  localparam int BIT_LSB = 9;
  localparam int ACC_BIT = 8;
  localparam int FILE_MSB = 7;
  localparam int FILE_LSB = 0;
  // encodings
  localparam logic [3:0] OPC_CLEAR_FILE_BIT = 4'h9;
  localparam logic [3:0] OPC_COND_BRANCH = 4'he;
  localparam logic [3:0] SUB_BRANCH_ON_NEGATIVE = 4'h6;
  localparam logic [3:0] SUB_BRANCH_ON_NO_CARRY = 4'h3;
  localparam logic [3:0] SUB_BRANCH_ON_NON_NEGATIVE = 4'h7;
  // access bank split and indexed window
  localparam logic [7:0] ACC_LOW_LIMIT = 8'h5f;
  localparam logic [3:0] ACC_HIGH_PAGE = 4'hf;
  localparam logic [3:0] ACC_LOW_PAGE = 4'h0;
  localparam logic ACC_SEL_ACCESS = 1'b0;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;
  typedef enum logic [0:0] {
    BCB_S_RUN = 1'b0,
    BCB_S_NOP = 1'b1
  } bcb_state_e;
endpackage
`default_nettype wire

// File: design/bcb_qphase.sv
`default_nettype none
module bcb_qphase (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // current quarter of the instruction cycle
  output logic [1:0] o_q
);
  import bcb_pkg::*;
  logic [1:0] next_q;

  // one quarter per clock; the wrap marks the start of each instruction cycle
  always_comb begin
    next_q = o_q + 2'h1;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_q <= Q1;
    end else begin
      o_q <= next_q;
    end
  end
endmodule
`default_nettype wire

// File: design/bcb_exec.sv
// Behaviour
// - clear_file_bit_op clears only the indexed bit of the addressed register, no flag.
// - an access bit of zero picks the access bank, one picks the bank named by bank_select_reg.
// - access bit zero, extended set on and file address at most 95 give indexed addressing.
// - branch_on_negative_op branches only when the negative flag is one.
// - branch_on_no_carry_op branches only when the carry flag is zero.
// - branch_on_non_negative_op branches only when the negative flag is zero.
// - a taken branch loads the incremented program counter plus twice the signed offset.
// - a branch takes one cycle untaken and two taken, and never changes a flag.
`default_nettype none
module bcb_exec (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // instruction from fetch
  input wire logic i_instr_valid,
  input wire logic [bcb_pkg::INSTR_W-1:0] i_instr,
  input wire logic [bcb_pkg::PC_W-1:0] i_pc_inc,
  // core state
  input wire logic i_flag_n,
  input wire logic i_flag_c,
  input wire logic i_ext_set_en,
  input wire logic [bcb_pkg::BANK_W-1:0] i_bank_select_reg,
  input wire logic [bcb_pkg::ADDR_W-1:0] i_index_base,
  // data memory
  input wire logic [bcb_pkg::DATA_W-1:0] i_rd_data,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [bcb_pkg::ADDR_W-1:0] o_mem_addr,
  output logic [bcb_pkg::DATA_W-1:0] o_mem_wdata,
  // program counter
  output logic o_pc_wr,
  output logic [bcb_pkg::PC_W-1:0] o_pc_value,
  // sequencing
  output logic [1:0] o_q_phase,
  output logic o_nop_cycle,
  output logic o_unknown_op
);
  import bcb_pkg::*;

  logic [1:0] q;
  bcb_state_e state, next_state;
  logic ir_vld, next_ir_vld;
  logic [INSTR_W-1:0] ir, next_ir;
  logic [PC_W-1:0] pc_inc, next_pc_inc;
  logic flag_n, next_flag_n;
  logic flag_c, next_flag_c;
  logic next_mem_rd, next_mem_wr, next_pc_wr, next_nop, next_unknown;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic [PC_W-1:0] next_pc_value;
  logic [1:0] next_q_phase;
  logic ir_is_bcf, ir_is_br, ir_take, in_is_bcf, in_is_br;
  logic [PC_W-1:0] br_target;

  bcb_qphase u_qphase (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_q(q)
  );

  function automatic logic is_branch(input logic [INSTR_W-1:0] w);
    is_branch = (w[OPC_MSB:OPC_LSB] == OPC_COND_BRANCH) &&
                ((w[SUB_MSB:SUB_LSB] == SUB_BRANCH_ON_NEGATIVE) ||
                 (w[SUB_MSB:SUB_LSB] == SUB_BRANCH_ON_NO_CARRY) ||
                 (w[SUB_MSB:SUB_LSB] == SUB_BRANCH_ON_NON_NEGATIVE));
  endfunction

  function automatic logic [ADDR_W-1:0] file_addr(input logic [INSTR_W-1:0] w);
    logic [7:0] f;
    f = w[FILE_MSB:FILE_LSB];
    if (w[ACC_BIT] != ACC_SEL_ACCESS) begin
      file_addr = {i_bank_select_reg, f};
    end else if (i_ext_set_en && (f <= ACC_LOW_LIMIT)) begin
      file_addr = i_index_base + {ACC_LOW_PAGE, f};
    end else if (f <= ACC_LOW_LIMIT) begin
      file_addr = {ACC_LOW_PAGE, f};
    end else begin
      file_addr = {ACC_HIGH_PAGE, f};
    end
  endfunction

  assign in_is_bcf = (i_instr[OPC_MSB:OPC_LSB] == OPC_CLEAR_FILE_BIT);
  assign in_is_br = is_branch(i_instr);
  assign ir_is_bcf = ir_vld && (ir[OPC_MSB:OPC_LSB] == OPC_CLEAR_FILE_BIT);
  assign ir_is_br = ir_vld && is_branch(ir);

  // flags are sampled at decode so a flag write landing mid-cycle cannot split the decision
  always_comb begin
    ir_take = 1'b0;
    case (ir[SUB_MSB:SUB_LSB])
      SUB_BRANCH_ON_NEGATIVE: ir_take = flag_n;
      SUB_BRANCH_ON_NO_CARRY: ir_take = !flag_c;
      SUB_BRANCH_ON_NON_NEGATIVE: ir_take = !flag_n;
      default: ir_take = 1'b0;
    endcase
    ir_take = ir_take && ir_is_br;
  end

  // offset doubled and sign extended; the address wraps at the top of program space
  assign br_target = pc_inc +
    PC_W'({{(PC_W-OFS_W-1){ir[OFS_W-1]}}, ir[OFS_W-1:0], 1'b0});

  always_comb begin
    next_state = state;
    next_ir_vld = ir_vld;
    next_ir = ir;
    next_pc_inc = pc_inc;
    next_flag_n = flag_n;
    next_flag_c = flag_c;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_pc_wr = 1'b0;
    next_mem_addr = o_mem_addr;
    next_mem_wdata = o_mem_wdata;
    next_pc_value = o_pc_value;
    next_q_phase = q + 2'h1;
    next_unknown = o_unknown_op;
    case (q)
      Q1: begin
        next_ir_vld = (state == BCB_S_RUN) && i_instr_valid;
        next_unknown = next_ir_vld && !in_is_bcf && !in_is_br;
        if (next_ir_vld) begin
          next_ir = i_instr;
          next_pc_inc = i_pc_inc;
          next_flag_n = i_flag_n;
          next_flag_c = i_flag_c;
          next_mem_rd = in_is_bcf;
          next_mem_addr = in_is_bcf ? file_addr(i_instr) : o_mem_addr;
        end
      end
      Q3: begin
        if (ir_is_bcf) begin
          next_mem_wdata = i_rd_data & ~(BIT_ONE << ir[BIT_MSB:BIT_LSB]);
          next_mem_wr = 1'b1;
        end
        if (ir_take) begin
          next_pc_value = br_target;
          next_pc_wr = 1'b1;
        end
      end
      Q4: begin
        if (ir_take) begin
          next_state = BCB_S_NOP;
        end else begin
          next_state = BCB_S_RUN;
        end
      end
      default: begin
      end
    endcase
    next_nop = (next_state == BCB_S_NOP);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= BCB_S_RUN;
      ir_vld <= 1'b0;
      ir <= '0;
      pc_inc <= '0;
      flag_n <= 1'b0;
      flag_c <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= '0;
      o_mem_wdata <= '0;
      o_pc_wr <= 1'b0;
      o_pc_value <= '0;
      o_nop_cycle <= 1'b0;
      o_unknown_op <= 1'b0;
      o_q_phase <= Q1;
    end else begin
      state <= next_state;
      ir_vld <= next_ir_vld;
      ir <= next_ir;
      pc_inc <= next_pc_inc;
      flag_n <= next_flag_n;
      flag_c <= next_flag_c;
      o_mem_rd <= next_mem_rd;
      o_mem_wr <= next_mem_wr;
      o_mem_addr <= next_mem_addr;
      o_mem_wdata <= next_mem_wdata;
      o_pc_wr <= next_pc_wr;
      o_pc_value <= next_pc_value;
      o_nop_cycle <= next_nop;
      o_unknown_op <= next_unknown;
      o_q_phase <= next_q_phase;
    end
  end

  // checks
  logic take_in;
  assign take_in = in_is_br && (q == Q1) && (state == BCB_S_RUN) && i_instr_valid;

  property p_clear_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_mem_wr |-> ((o_mem_wdata | (BIT_ONE << ir[BIT_MSB:BIT_LSB])) == ($past(i_rd_data) |
      (BIT_ONE << ir[BIT_MSB:BIT_LSB]))) && (o_mem_wdata[ir[BIT_MSB:BIT_LSB]] == 1'b0);
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear wrong");

  property p_banked;
    @(posedge i_clk) disable iff (i_sys_rst)
    (q == Q1 && state == BCB_S_RUN && i_instr_valid && in_is_bcf && i_instr[ACC_BIT])
      |=> o_mem_rd && o_mem_addr == {$past(i_bank_select_reg), $past(i_instr[FILE_MSB:FILE_LSB])};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    @(posedge i_clk) disable iff (i_sys_rst)
    (q == Q1 && state == BCB_S_RUN && i_instr_valid && in_is_bcf && !i_instr[ACC_BIT] &&
      i_ext_set_en && i_instr[FILE_MSB:FILE_LSB] <= ACC_LOW_LIMIT)
      |=> o_mem_addr == $past(i_index_base) + {ACC_LOW_PAGE, $past(i_instr[FILE_MSB:FILE_LSB])};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_neg_branch;
    @(posedge i_clk) disable iff (i_sys_rst)
    (take_in && i_instr[SUB_MSB:SUB_LSB] == SUB_BRANCH_ON_NEGATIVE) |->
      ##3 (o_pc_wr == $past(i_flag_n, 3));
  endproperty
  a_neg_branch: assert property (p_neg_branch)
    else $error("negative branch decision wrong");

  property p_nc_branch;
    @(posedge i_clk) disable iff (i_sys_rst)
    (take_in && i_instr[SUB_MSB:SUB_LSB] == SUB_BRANCH_ON_NO_CARRY) |->
      ##3 (o_pc_wr == !$past(i_flag_c, 3));
  endproperty
  a_nc_branch: assert property (p_nc_branch)
    else $error("no carry branch decision wrong");

  property p_nn_branch;
    @(posedge i_clk) disable iff (i_sys_rst)
    (take_in && i_instr[SUB_MSB:SUB_LSB] == SUB_BRANCH_ON_NON_NEGATIVE) |->
      ##3 (o_pc_wr == !$past(i_flag_n, 3));
  endproperty
  a_nn_branch: assert property (p_nn_branch)
    else $error("non negative branch decision wrong");

  property p_target;
    @(posedge i_clk) disable iff (i_sys_rst)
    take_in ##3 o_pc_wr |-> o_pc_value == $past(i_pc_inc, 3) +
      PC_W'({{(PC_W-OFS_W-1){$past(i_instr[OFS_W-1], 3)}}, $past(i_instr[OFS_W-1:0], 3), 1'b0});
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_idle_cycle;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_pc_wr |=> o_nop_cycle [*4] ##1 !o_nop_cycle;
  endproperty
  a_idle_cycle: assert property (p_idle_cycle)
    else $error("taken branch idle cycle wrong");

  property p_quarters;
    @(posedge i_clk) disable iff (i_sys_rst)
    (o_mem_rd |-> o_q_phase == Q2) and ((o_mem_wr || o_pc_wr) |-> o_q_phase == Q4);
  endproperty
  a_quarters: assert property (p_quarters) else $error("activity in wrong quarter");

  c_bcf: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_mem_rd ##2 o_mem_wr);
  c_taken: cover property (@(posedge i_clk) disable iff (i_sys_rst) o_pc_wr ##1 o_nop_cycle);
  c_back: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pc_wr && o_pc_value < pc_inc);
  c_untaken: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    take_in ##3 !o_pc_wr);
endmodule
`default_nettype wire

// File: verif/bit_clear_and_flag_branch_exec_tb.sv
`default_nettype none
module bit_clear_and_flag_branch_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bcb_pkg::*;

  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_instr_valid = 1'b0;
  logic [INSTR_W-1:0] i_instr = 16'h0000;
  logic [PC_W-1:0] i_pc_inc = 21'h000000;
  logic i_flag_n = 1'b0;
  logic i_flag_c = 1'b0;
  logic i_ext_set_en = 1'b0;
  logic [BANK_W-1:0] i_bank_select_reg = 4'h0;
  logic [ADDR_W-1:0] i_index_base = 12'h000;
  logic [DATA_W-1:0] i_rd_data = 8'h00;
  logic o_mem_rd, o_mem_wr, o_pc_wr, o_nop_cycle, o_unknown_op;
  logic [ADDR_W-1:0] o_mem_addr;
  logic [DATA_W-1:0] o_mem_wdata;
  logic [PC_W-1:0] o_pc_value;
  logic [1:0] o_q_phase;
  int mismatches = 0;
  int tests_run = 0;
  // per-cycle samples, bit k is the k-th cycle after the decode edge
  logic [8:1] rd_s, wr_s, pcw_s, nop_s, unk_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] wd_s;
  logic [PC_W-1:0] pcv_s;

  always #2 i_clk = ~i_clk;

  bcb_exec u_dut (.i_clk, .i_sys_rst, .i_instr_valid, .i_instr, .i_pc_inc, .i_flag_n,
    .i_flag_c, .i_ext_set_en, .i_bank_select_reg, .i_index_base, .i_rd_data, .o_mem_rd,
    .o_mem_wr, .o_mem_addr, .o_mem_wdata, .o_pc_wr, .o_pc_value, .o_q_phase, .o_nop_cycle,
    .o_unknown_op);

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // hold keeps valid up through Q3 of the idle cycle, so a second take there would show
  task automatic run_op(input logic [15:0] ins, input logic n, input logic c,
                        input logic hold);
    int k;
    k = 0;
    while (!(o_q_phase === Q1 && o_nop_cycle === 1'b0) && k < 16) begin
      @(negedge i_clk);
      k++;
    end
    chk(k < 16, "no decode slot");
    i_instr_valid = 1'b1;
    i_instr = ins;
    i_flag_n = n;
    i_flag_c = c;
    for (int j = 1; j <= 8; j++) begin
      @(negedge i_clk);
      if (!hold || j >= 7) begin
        i_instr_valid = 1'b0;
      end
      rd_s[j] = o_mem_rd;
      wr_s[j] = o_mem_wr;
      pcw_s[j] = o_pc_wr;
      nop_s[j] = o_nop_cycle;
      unk_s[j] = o_unknown_op;
      if (j == 1) begin
        addr_s = o_mem_addr;
      end
      if (j == 3) begin
        wd_s = o_mem_wdata;
        pcv_s = o_pc_value;
      end
    end
  endtask

  task automatic sc_bit_clear();
    logic [7:0] f;
    logic [11:0] ea;
    for (int i = 0; i < 8; i++) begin
      f = i[2] ? 8'h60 : 8'h5f;
      i_ext_set_en = i[1];
      i_bank_select_reg = 4'ha;
      i_index_base = 12'hff0;
      i_rd_data = 8'hc7 ^ 8'(i * 19);
      if (i[0]) begin
        ea = {i_bank_select_reg, f};
      end else if (f <= 8'h5f && i[1]) begin
        ea = i_index_base + {4'h0, f};
      end else if (f <= 8'h5f) begin
        ea = {4'h0, f};
      end else begin
        ea = {4'hf, f};
      end
      run_op({OPC_CLEAR_FILE_BIT, 3'(i), i[0], f}, 1'b0, 1'b0, 1'b0);
      chk(rd_s === 8'h01 && addr_s === ea, "clear read");
      chk(wr_s === 8'h04 && wd_s === (i_rd_data & ~(8'h01 << i)), "clear wr");
      chk(pcw_s === 8'h00 && unk_s[1] === 1'b0, "clear side effect");
    end
  endtask

  task automatic sc_branch();
    logic [3:0] sub;
    logic [7:0] ofs;
    logic tk;
    logic [PC_W-1:0] tgt;
    for (int i = 0; i < 12; i++) begin
      sub = (i < 4) ? SUB_BRANCH_ON_NEGATIVE :
            (i < 8) ? SUB_BRANCH_ON_NO_CARRY : SUB_BRANCH_ON_NON_NEGATIVE;
      ofs = i[0] ? 8'h80 : 8'h7f;
      i_pc_inc = 21'h1fff00 + 21'(i * 4);
      tk = (i < 4) ? i[0] : (i < 8) ? !i[1] : !i[0];
      tgt = i_pc_inc + {{12{ofs[7]}}, ofs, 1'b0};
      run_op({OPC_COND_BRANCH, sub, ofs}, i[0], i[1], tk);
      chk(pcw_s === (tk ? 8'h04 : 8'h00), "branch decision");
      chk(tk === 1'b0 || pcv_s === tgt, "branch target");
      chk(nop_s === (tk ? 8'h78 : 8'h00), "branch idle cycle");
      chk((rd_s | wr_s) === 8'h00, "branch touched memory");
    end
  endtask

  // a reset inside the idle cycle of a taken branch must drop everything and restart at Q1
  task automatic sc_reset();
    int k;
    k = 0;
    while (o_q_phase !== Q1 && k < 8) begin
      @(negedge i_clk);
      k++;
    end
    i_instr_valid = 1'b1;
    i_instr = {OPC_COND_BRANCH, SUB_BRANCH_ON_NEGATIVE, 8'h10};
    i_flag_n = 1'b1;
    repeat (5) @(negedge i_clk);
    chk(o_nop_cycle === 1'b1 && o_q_phase === Q2, "idle before reset");
    i_sys_rst = 1'b1;
    i_instr_valid = 1'b0;
    @(negedge i_clk);
    chk({o_mem_rd, o_mem_wr, o_pc_wr} === 3'h0, "reset strobes");
    chk({o_nop_cycle, o_unknown_op} === 2'h0, "reset flags");
    chk(o_q_phase === Q1 && o_pc_value === 21'h000000, "reset quarter");
    chk(o_mem_addr === 12'h000, "reset address");
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    chk(o_q_phase === Q2 && o_nop_cycle === 1'b0, "first quarter after reset");
  endtask

  task automatic sc_unknown();
    logic [15:0] w [2];
    w[0] = 16'h8000;
    w[1] = 16'he500;
    for (int i = 0; i < 2; i++) begin
      run_op(w[i], 1'b1, 1'b0, 1'b0);
      chk((rd_s | wr_s | pcw_s) === 8'h00 && unk_s[1] === 1'b1, "foreign word");
    end
  endtask

  task automatic print_verdict();
    $display("checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    @(negedge i_clk);
    sc_bit_clear();
    sc_branch();
    sc_reset();
    sc_unknown();
    print_verdict();
  end

  // the whole run needs about 200 cycles; this is far beyond that
  initial begin
    #20000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
